// >>> design/dpac_pkg.sv
// constants and types for the data pointer and address control block
package dpac_pkg;
  localparam int unsigned ADDR_W = 12;
  // register indexes; byte address is four times the index
  localparam logic [9:0] IDX_P0_LO = 10'h082;
  localparam logic [9:0] IDX_P0_HI = 10'h083;
  localparam logic [9:0] IDX_P1_LO = 10'h084;
  localparam logic [9:0] IDX_P1_HI = 10'h085;
  localparam logic [9:0] IDX_SEL = 10'h086;
  localparam logic [9:0] IDX_WAIT = 10'h092;
  localparam logic [9:0] IDX_P0_TOP = 10'h093;
  localparam logic [9:0] IDX_P1_TOP = 10'h095;
  localparam logic [9:0] IDX_MODE = 10'h09d;
  localparam logic [9:0] IDX_RI_HIGH = 10'h0da;
  localparam logic [9:0] IDX_RI_UPPER = 10'h0ea;
  // addressing_mode_control fields
  localparam int unsigned MODE_SRC_BIT = 3;
  localparam int unsigned MODE_STACK_BIT = 2;
  localparam int unsigned MODE_AM_LSB = 0;
  localparam int unsigned MODE_AM_MSB = 1;
  // pointer_select_control fields
  localparam int unsigned SEL_DIR1_BIT = 7;
  localparam int unsigned SEL_DIR0_BIT = 6;
  localparam int unsigned SEL_TOGGLE_BIT = 5;
  localparam int unsigned SEL_ACTIVE_BIT = 0;
  localparam int unsigned WAIT_MSB = 3;
  // reset values, pointer step sizes and bus response codes
  localparam logic [3:0] WAIT_RST = 4'h7;
  localparam logic [19:0] PC_RST = 20'h07000;
  localparam logic [15:0] STEP_UP = 16'h0001;
  localparam logic [15:0] STEP_DOWN = 16'hffff;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic {FETCH_IDLE, FETCH_WAIT} dpac_fetch_t;
  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } dpac_axi_req_t;
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } dpac_axi_rsp_t;
  typedef struct packed {
    logic ptr_done;
    logic ptr_inc;
    logic [7:0] port2_latch;
    logic [7:0] ri_low;
    logic fetch_req;
    logic pc_load;
    logic [19:0] pc_value;
    logic [7:0] flash_data;
  } dpac_core_in_t;
  typedef struct packed {
    logic [23:0] first_data_pointer_addr;
    logic [23:0] ri_addr;
    logic flash_rd;
    logic [19:0] flash_addr;
    logic fetch_done;
    logic [7:0] fetch_data;
    logic prog_wide;
    logic stack_ext;
  } dpac_core_out_t;
  // true for every index that holds a register
  function automatic logic dpac_mapped(input logic [9:0] idx);
    case (idx)
      IDX_P0_LO, IDX_P0_HI, IDX_P1_LO, IDX_P1_HI, IDX_SEL, IDX_WAIT,
      IDX_P0_TOP, IDX_P1_TOP, IDX_MODE, IDX_RI_HIGH, IDX_RI_UPPER: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : dpac_mapped
endpackage : dpac_pkg

// >>> design/dpac_top.sv
// data pointer, addressing mode and program wait-state control with axi4-lite access
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - indirect move high byte from port2 or register
// - stack indicator shows standard or extended stack
// - stack indicator ignores software writes
// - mode 00 sixteen bit, 1x twenty bit
// - addressing mode register resets to zero
// - wait states stretch program fetches only
// - fetch length equals wait field plus one
// - wait register resets to seven, holds until written
// - increment direction chosen per pointer bit
// - auto toggle flips selection after pointer use
// - select bit picks pointer, reads current choice
// - pointer control resets to zero
// - four pointer bytes read, write, reset zero
// - top byte stored and driven as the upper byte of the pointer address
// - indirect move upper byte from own register
// - pointer move upper byte from active top
module dpac_top
  import dpac_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire dpac_axi_req_t axi_in,
  output var dpac_axi_rsp_t axi_out,
  input wire dpac_core_in_t core_in,
  output var dpac_core_out_t core_out
);

  typedef struct packed {
    logic [7:0] pointer0_low_byte;
    logic [7:0] pointer0_high_byte;
    logic [7:0] pointer1_low_byte;
    logic [7:0] pointer1_high_byte;
    logic [7:0] pointer0_top_byte;
    logic [7:0] pointer1_top_byte;
    logic pointer1_step_direction;
    logic pointer0_step_direction;
    logic auto_toggle_pointer;
    logic pointer_select;
    logic [3:0] program_wait_states;
    logic high_byte_source_select;
    logic stack_width_indicator;
    logic [1:0] address_mode;
    logic [7:0] indirect_move_high_byte;
    logic [7:0] indirect_move_upper_byte;
    logic aw_held;
    logic [ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [7:0] w_data;
    logic w_lane0;
    dpac_fetch_t fsm;
    logic [3:0] wait_cnt;
    dpac_axi_rsp_t rsp;
    dpac_core_out_t cout;
  } dpac_state_t;

  dpac_state_t st;
  dpac_state_t next_st;
  logic wr_fire;
  logic wr_en;
  logic [9:0] widx;
  logic [9:0] ridx;
  logic [31:0] rword;
  logic [15:0] step;

  // single next-state process for bus, pointers and fetch
  always_comb begin
    next_st = st;
    wr_fire = 1'b0;
    wr_en = 1'b0;
    widx = st.aw_addr[ADDR_W-1:2];
    ridx = axi_in.araddr[ADDR_W-1:2];
    rword = 32'h0000_0000;
    step = STEP_UP;
    next_st.cout.fetch_done = 1'b0;

    // address and data are taken independently, in either order
    if (axi_in.awvalid && st.rsp.awready) begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = axi_in.awaddr;
    end
    if (axi_in.wvalid && st.rsp.wready) begin
      next_st.w_held = 1'b1;
      next_st.w_data = axi_in.wdata[7:0];
      next_st.w_lane0 = axi_in.wstrb[0];
    end
    if (st.rsp.bvalid && axi_in.bready) begin
      next_st.rsp.bvalid = 1'b0;
    end

    // a write completes once both halves are in and no response waits
    if (st.aw_held && st.w_held && !st.rsp.bvalid) begin
      wr_fire = 1'b1;
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.rsp.bvalid = 1'b1;
      wr_en = st.w_lane0 && (st.aw_addr[1:0] == 2'h0);
      if (dpac_mapped(widx) && (st.aw_addr[1:0] == 2'h0)) begin
        next_st.rsp.bresp = RESP_OKAY;
      end else begin
        next_st.rsp.bresp = RESP_SLVERR;
      end
    end

    // register writes; upper byte lanes carry nothing
    if (wr_en) begin
      case (widx)
        IDX_P0_LO: next_st.pointer0_low_byte = st.w_data;
        IDX_P0_HI: next_st.pointer0_high_byte = st.w_data;
        IDX_P1_LO: next_st.pointer1_low_byte = st.w_data;
        IDX_P1_HI: next_st.pointer1_high_byte = st.w_data;
        IDX_SEL: begin
          next_st.pointer1_step_direction = st.w_data[SEL_DIR1_BIT];
          next_st.pointer0_step_direction = st.w_data[SEL_DIR0_BIT];
          next_st.auto_toggle_pointer = st.w_data[SEL_TOGGLE_BIT];
          next_st.pointer_select = st.w_data[SEL_ACTIVE_BIT];
        end
        IDX_WAIT: next_st.program_wait_states = st.w_data[WAIT_MSB:0];
        IDX_P0_TOP: next_st.pointer0_top_byte = st.w_data;
        IDX_P1_TOP: next_st.pointer1_top_byte = st.w_data;
        IDX_MODE: begin
          // stack indicator bit is not written
          next_st.high_byte_source_select = st.w_data[MODE_SRC_BIT];
          next_st.address_mode = st.w_data[MODE_AM_MSB:MODE_AM_LSB];
        end
        IDX_RI_HIGH: next_st.indirect_move_high_byte = st.w_data;
        IDX_RI_UPPER: next_st.indirect_move_upper_byte = st.w_data;
        default: next_st.w_lane0 = st.w_lane0;
      endcase
    end

    // pointer step at end of the instruction, applied over any bus write
    if (core_in.ptr_done) begin
      if (core_in.ptr_inc) begin
        if (next_st.pointer_select) begin
          step = next_st.pointer1_step_direction ? STEP_DOWN : STEP_UP;
          {next_st.pointer1_high_byte, next_st.pointer1_low_byte} =
            {next_st.pointer1_high_byte, next_st.pointer1_low_byte} + step;
        end else begin
          step = next_st.pointer0_step_direction ? STEP_DOWN : STEP_UP;
          {next_st.pointer0_high_byte, next_st.pointer0_low_byte} =
            {next_st.pointer0_high_byte, next_st.pointer0_low_byte} + step;
        end
      end
      if (next_st.auto_toggle_pointer) begin
        next_st.pointer_select = ~next_st.pointer_select;
      end
    end

    // extended stack follows the twenty bit program mode
    next_st.stack_width_indicator = next_st.address_mode[MODE_AM_MSB];

    // read channel: one read outstanding, answer registered
    if (st.rsp.rvalid && axi_in.rready) begin
      next_st.rsp.rvalid = 1'b0;
    end
    if (axi_in.arvalid && st.rsp.arready) begin
      case (ridx)
        IDX_P0_LO: rword[7:0] = st.pointer0_low_byte;
        IDX_P0_HI: rword[7:0] = st.pointer0_high_byte;
        IDX_P1_LO: rword[7:0] = st.pointer1_low_byte;
        IDX_P1_HI: rword[7:0] = st.pointer1_high_byte;
        IDX_SEL: begin
          rword[SEL_DIR1_BIT] = st.pointer1_step_direction;
          rword[SEL_DIR0_BIT] = st.pointer0_step_direction;
          rword[SEL_TOGGLE_BIT] = st.auto_toggle_pointer;
          rword[SEL_ACTIVE_BIT] = st.pointer_select;
        end
        IDX_WAIT: rword[WAIT_MSB:0] = st.program_wait_states;
        IDX_P0_TOP: rword[7:0] = st.pointer0_top_byte;
        IDX_P1_TOP: rword[7:0] = st.pointer1_top_byte;
        IDX_MODE: begin
          rword[MODE_SRC_BIT] = st.high_byte_source_select;
          rword[MODE_STACK_BIT] = st.stack_width_indicator;
          rword[MODE_AM_MSB:MODE_AM_LSB] = st.address_mode;
        end
        IDX_RI_HIGH: rword[7:0] = st.indirect_move_high_byte;
        IDX_RI_UPPER: rword[7:0] = st.indirect_move_upper_byte;
        default: rword = 32'h0000_0000;
      endcase
      next_st.rsp.rvalid = 1'b1;
      next_st.rsp.rdata = rword;
      if (dpac_mapped(ridx) && (axi_in.araddr[1:0] == 2'h0)) begin
        next_st.rsp.rresp = RESP_OKAY;
      end else begin
        next_st.rsp.rresp = RESP_SLVERR;
      end
    end
    next_st.rsp.awready = !next_st.aw_held;
    next_st.rsp.wready = !next_st.w_held;
    next_st.rsp.arready = !next_st.rsp.rvalid;

    // program fetch; the count is latched so a mid-fetch write waits
    case (st.fsm)
      FETCH_IDLE: begin
        if (core_in.pc_load) begin
          next_st.cout.flash_addr = core_in.pc_value;
        end else if (core_in.fetch_req) begin
          next_st.cout.flash_rd = 1'b1;
          next_st.wait_cnt = st.program_wait_states;
          next_st.fsm = FETCH_WAIT;
        end
      end
      FETCH_WAIT: begin
        if (st.wait_cnt == 4'h0) begin
          next_st.cout.flash_rd = 1'b0;
          next_st.cout.fetch_data = core_in.flash_data;
          next_st.cout.fetch_done = 1'b1;
          next_st.fsm = FETCH_IDLE;
          if (st.address_mode[MODE_AM_MSB]) begin
            next_st.cout.flash_addr = st.cout.flash_addr + 20'h00001;
          end else begin
            next_st.cout.flash_addr = {4'h0, st.cout.flash_addr[15:0] + STEP_UP};
          end
        end else begin
          next_st.wait_cnt = st.wait_cnt - 4'h1;
        end
      end
      default: next_st.fsm = FETCH_IDLE;
    endcase

    // data addresses never wait on the fetch counter
    if (next_st.pointer_select) begin
      next_st.cout.first_data_pointer_addr = {next_st.pointer1_top_byte, next_st.pointer1_high_byte,
        next_st.pointer1_low_byte};
    end else begin
      next_st.cout.first_data_pointer_addr = {next_st.pointer0_top_byte, next_st.pointer0_high_byte,
        next_st.pointer0_low_byte};
    end
    next_st.cout.ri_addr[23:16] = st.indirect_move_upper_byte;
    next_st.cout.ri_addr[15:8] = st.high_byte_source_select ?
      st.indirect_move_high_byte : core_in.port2_latch;
    next_st.cout.ri_addr[7:0] = core_in.ri_low;
    next_st.cout.prog_wide = next_st.address_mode[MODE_AM_MSB];
    next_st.cout.stack_ext = next_st.stack_width_indicator;
  end

  // state register; reset leaves every register at its default
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
      st.program_wait_states <= WAIT_RST;
      st.fsm <= FETCH_IDLE;
      st.cout.flash_addr <= PC_RST;
      st.rsp.awready <= 1'b1;
      st.rsp.wready <= 1'b1;
      st.rsp.arready <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign axi_out = st.rsp;
  assign core_out = st.cout;

  // helper: measure the read strobe length of each fetch
  logic [4:0] rd_len;
  logic [3:0] wait_lat;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rd_len <= 5'h00;
      wait_lat <= 4'h0;
    end else if (st.fsm == FETCH_IDLE && core_in.fetch_req && !core_in.pc_load) begin
      rd_len <= 5'h00;
      wait_lat <= st.program_wait_states;
    end else if (st.cout.flash_rd) begin
      rd_len <= rd_len + 5'h01;
    end
  end

  sequence fetch_start_s;
    st.fsm == FETCH_IDLE && core_in.fetch_req && !core_in.pc_load;
  endsequence

  sequence fetch_end_s;
    st.cout.fetch_done;
  endsequence

  sequence step_p0_s;
    core_in.ptr_done && core_in.ptr_inc && !wr_fire && !st.pointer_select;
  endsequence

  // an attempt begun on the releasing edge is vacuous; reset cleared the output there
  ri_source_a: assert property (@(posedge mclk) disable iff (!arst_n)
    arst_n ##1 1'b1 |-> st.cout.ri_addr[15:8] == ($past(st.high_byte_source_select) ?
      $past(st.indirect_move_high_byte) : $past(core_in.port2_latch)))
    else $error("indirect move high byte from wrong source");

  ri_upper_a: assert property (@(posedge mclk) disable iff (!arst_n)
    ##1 1'b1 |-> st.cout.ri_addr[23:16] == $past(st.indirect_move_upper_byte))
    else $error("indirect move upper byte wrong");

  stack_ro_a: assert property (@(posedge mclk) disable iff (!arst_n)
    st.stack_width_indicator == st.address_mode[MODE_AM_MSB] &&
    st.cout.stack_ext == st.stack_width_indicator)
    else $error("stack indicator changed by software");

  mode_wide_a: assert property (@(posedge mclk) disable iff (!arst_n)
    st.cout.prog_wide == st.address_mode[MODE_AM_MSB])
    else $error("program width does not follow mode");

  reset_vals_a: assert property (@(posedge mclk)
    !arst_n |-> st.program_wait_states == WAIT_RST && st.address_mode == 2'h0 &&
      !st.high_byte_source_select && !st.pointer_select && !st.auto_toggle_pointer)
    else $error("register default wrong under reset");

  data_nowait_a: assert property (@(posedge mclk) disable iff (!arst_n)
    st.fsm == FETCH_WAIT |=> st.cout.ri_addr[7:0] == $past(core_in.ri_low))
    else $error("data address stalled by fetch wait");

  fetch_len_a: assert property (@(posedge mclk) disable iff (!arst_n)
    fetch_end_s |-> rd_len == {1'b0, wait_lat} + 5'h01)
    else $error("fetch strobe length not wait plus one");

  fetch_seq_a: assert property (@(posedge mclk) disable iff (!arst_n)
    fetch_start_s ##0 (st.program_wait_states == 4'h0) |=> st.cout.flash_rd ##1 fetch_end_s)
    else $error("single cycle fetch did not complete");

  step_dir_a: assert property (@(posedge mclk) disable iff (!arst_n)
    step_p0_s |=> {st.pointer0_high_byte, st.pointer0_low_byte} ==
      $past({st.pointer0_high_byte, st.pointer0_low_byte}) +
      ($past(st.pointer0_step_direction) ? STEP_DOWN : STEP_UP))
    else $error("pointer 0 stepped the wrong way");

  toggle_a: assert property (@(posedge mclk) disable iff (!arst_n)
    core_in.ptr_done && !wr_fire |=>
      st.pointer_select == ($past(st.pointer_select) ^ $past(st.auto_toggle_pointer)))
    else $error("pointer selection toggle wrong");

  active_addr_a: assert property (@(posedge mclk) disable iff (!arst_n)
    st.cout.first_data_pointer_addr == (st.pointer_select ?
      {st.pointer1_top_byte, st.pointer1_high_byte, st.pointer1_low_byte} :
      {st.pointer0_top_byte, st.pointer0_high_byte, st.pointer0_low_byte}))
    else $error("pointer address not from active pointer");

  // pointer 1 step, only when no bus write lands in the same cycle
  sequence step_p1_s;
    core_in.ptr_done && core_in.ptr_inc && !wr_fire && st.pointer_select;
  endsequence

  step_dir1_a: assert property (@(posedge mclk) disable iff (!arst_n)
    step_p1_s |=> {st.pointer1_high_byte, st.pointer1_low_byte} ==
      $past({st.pointer1_high_byte, st.pointer1_low_byte}) +
      ($past(st.pointer1_step_direction) ? STEP_DOWN : STEP_UP))
    else $error("pointer 1 stepped the wrong way");

  // the wait field moves only on a bus write to its own index
  wait_hold_a: assert property (@(posedge mclk) disable iff (!arst_n)
    !(wr_en && (widx == IDX_WAIT)) |=> $stable(st.program_wait_states))
    else $error("wait states changed without a write");

  // flash data is taken on the edge that ends the wait, strobe drops there
  capture_data_a: assert property (@(posedge mclk) disable iff (!arst_n)
    st.fsm == FETCH_WAIT && st.wait_cnt == 4'h0 |=>
      st.cout.fetch_data == $past(core_in.flash_data) && !st.cout.flash_rd)
    else $error("fetch data not captured at end of wait");

  pc_advance_a: assert property (@(posedge mclk) disable iff (!arst_n)
    fetch_end_s |-> st.cout.flash_addr[15:0] == $past(st.cout.flash_addr[15:0]) + STEP_UP)
    else $error("program counter did not advance after fetch");

  // a write with both halves held answers on the next edge and frees both channels
  write_resp_a: assert property (@(posedge mclk) disable iff (!arst_n)
    st.aw_held && st.w_held && !st.rsp.bvalid |=>
      st.rsp.bvalid && st.rsp.awready && st.rsp.wready)
    else $error("write response not raised after both halves");

  // a taken read answers on the next edge and blocks a second address
  read_resp_a: assert property (@(posedge mclk) disable iff (!arst_n)
    axi_in.arvalid && st.rsp.arready |=> st.rsp.rvalid && !st.rsp.arready)
    else $error("read response not raised after address");

endmodule : dpac_top
`default_nettype wire

// >>> test/data_pointer_address_control_tb.sv
// self-checking bench for the data pointer and address control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin err_count++; \
  $display("mismatch %s expected %0h seen %0h", nm, exp, got); end end
module data_pointer_address_control_tb;
  import dpac_pkg::*;
  logic mclk = 1'b0;
  logic arst_n = 1'b1;
  dpac_axi_req_t req = '0;
  dpac_axi_rsp_t rsp;
  dpac_core_in_t cdrv = '0;
  dpac_core_in_t cin;
  dpac_core_out_t core_o;
  logic [7:0] fdata;
  logic [4:0] access = 5'h08;
  int err_count = 0;
  int checked = 0;
  int cycles = 0;
  always #2.5 mclk = ~mclk;
  // flash data joins the bench-driven core inputs
  always_comb begin
    cin = cdrv;
    cin.flash_data = fdata;
  end
  dpac_top i_dut (.mclk(mclk), .arst_n(arst_n), .axi_in(req), .axi_out(rsp), .core_in(cin),
    .core_out(core_o));
  dpac_flash_model i_flash (.mclk(mclk), .arst_n(arst_n), .flash_rd(core_o.flash_rd),
    .flash_addr(core_o.flash_addr), .access_cyc(access), .flash_data(fdata));
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done
  // hang guard: whole run needs well under a thousand cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      test_done();
    end
  end
  // write one register; address and data offered together, each dropped when taken
  task automatic axi_wr(input logic [9:0] idx, input logic [7:0] d, output logic [1:0] r);
    @(posedge mclk);
    req.awvalid <= 1'b1;
    req.awaddr <= {idx, 2'b00};
    req.wvalid <= 1'b1;
    req.wdata <= {24'h000000, d};
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    forever begin
      @(posedge mclk);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
      if (req.bready && rsp.bvalid) begin
        r = rsp.bresp;
        req.bready <= 1'b0;
        break;
      end
    end
  endtask : axi_wr
  task automatic axi_rd(input logic [9:0] idx, output logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    req.arvalid <= 1'b1;
    req.araddr <= {idx, 2'b00};
    req.rready <= 1'b1;
    forever begin
      @(posedge mclk);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      if (req.rready && rsp.rvalid) begin
        d = rsp.rdata;
        r = rsp.rresp;
        req.rready <= 1'b0;
        break;
      end
    end
  endtask : axi_rd
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    logic [1:0] r;
    axi_wr(idx, d, r);
    `CHK("write resp", RESP_OKAY, r)
  endtask : wr
  task automatic chk_rd(input logic [9:0] idx, input logic [7:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(idx, d, r);
    `CHK("read data", {24'h000000, exp}, d)
    `CHK("read resp", RESP_OKAY, r)
  endtask : chk_rd
  task automatic t_reset;
    logic [9:0] idx[11] = '{IDX_P0_LO, IDX_P0_HI, IDX_P1_LO, IDX_P1_HI, IDX_SEL, IDX_WAIT,
      IDX_P0_TOP, IDX_P1_TOP, IDX_MODE, IDX_RI_HIGH, IDX_RI_UPPER};
    logic [31:0] d;
    logic [1:0] r;
    for (int i = 0; i < 11; i++) begin
      chk_rd(idx[i], (idx[i] == IDX_WAIT) ? 8'h07 : 8'h00);
    end
    // a hole in the map must answer with an error and no data
    axi_rd(10'h081, d, r);
    `CHK("hole data", 32'h00000000, d)
    `CHK("hole resp", RESP_SLVERR, r)
    axi_wr(10'h081, 8'h5a, r);
    `CHK("hole write resp", RESP_SLVERR, r)
    $display("test reset values done");
  endtask : t_reset
  task automatic t_mode;
    logic [7:0] wv[4] = '{8'h04, 8'h09, 8'h02, 8'h03};
    logic [7:0] rv[4] = '{8'h00, 8'h09, 8'h06, 8'h07};
    for (int i = 0; i < 4; i++) begin
      wr(IDX_MODE, wv[i]);
      chk_rd(IDX_MODE, rv[i]);
      `CHK("prog_wide", wv[i][1], core_o.prog_wide)
      `CHK("stack_ext", wv[i][1], core_o.stack_ext)
    end
    wr(IDX_MODE, 8'h00);
    $display("test addressing mode done");
  endtask : t_mode
  task automatic t_indirect;
    cdrv.port2_latch <= 8'ha5;
    cdrv.ri_low <= 8'h3c;
    wr(IDX_RI_HIGH, 8'h77);
    wr(IDX_RI_UPPER, 8'h81);
    @(posedge mclk);
    #1;
    `CHK("ri_addr port2", 24'h81a53c, core_o.ri_addr)
    wr(IDX_MODE, 8'h08);
    @(posedge mclk);
    #1;
    `CHK("ri_addr high reg", 24'h81773c, core_o.ri_addr)
    $display("test indirect address done");
  endtask : t_indirect
  // one program fetch; the flash model gives data only after w+1 cycles
  task automatic fetch_run(input logic [3:0] w, input logic do_wr, input logic [19:0] nxt);
    logic [19:0] a;
    int n;
    if (do_wr) wr(IDX_WAIT, {4'h0, w});
    access <= 5'(w) + 5'h01;
    a = core_o.flash_addr;
    cdrv.fetch_req <= 1'b1;
    @(posedge mclk);
    cdrv.fetch_req <= 1'b0;
    n = 0;
    #1;
    while (core_o.flash_rd === 1'b1 && n < 20) begin
      n++;
      @(posedge mclk);
      #1;
    end
    `CHK("fetch cycles", 32'(w) + 32'd1, n)
    `CHK("fetch done", 1'b1, core_o.fetch_done)
    `CHK("fetch data", a[7:0] ^ 8'h5a, core_o.fetch_data)
    `CHK("fetch addr", nxt, core_o.flash_addr)
  endtask : fetch_run
  task automatic t_fetch;
    fetch_run(4'h7, 1'b0, 20'h07001);
    fetch_run(4'h0, 1'b1, 20'h07002);
    fetch_run(4'hf, 1'b1, 20'h07003);
    fetch_run(4'h1, 1'b1, 20'h07004);
    $display("test fetch wait states done");
  endtask : t_fetch
  task automatic ptr_step(input logic inc, input logic [23:0] exp);
    @(posedge mclk);
    cdrv.ptr_done <= 1'b1;
    cdrv.ptr_inc <= inc;
    @(posedge mclk);
    cdrv.ptr_done <= 1'b0;
    #1;
    `CHK("first_data_pointer_addr", exp, core_o.first_data_pointer_addr)
  endtask : ptr_step
  task automatic t_pointer;
    wr(IDX_P0_LO, 8'hff);
    wr(IDX_P0_HI, 8'h12);
    wr(IDX_P1_LO, 8'h00);
    wr(IDX_P1_HI, 8'h00);
    wr(IDX_P0_TOP, 8'h3c);
    wr(IDX_P1_TOP, 8'hc3);
    wr(IDX_SEL, 8'h00);
    ptr_step(1'b1, 24'h3c1300);
    wr(IDX_SEL, 8'h61);
    ptr_step(1'b1, 24'h3c1300);
    chk_rd(IDX_SEL, 8'h60);
    chk_rd(IDX_P1_LO, 8'h01);
    ptr_step(1'b1, 24'hc30001);
    chk_rd(IDX_P0_LO, 8'hff);
    wr(IDX_SEL, 8'ha1);
    ptr_step(1'b1, 24'h3c12ff);
    ptr_step(1'b0, 24'hc30000);
    chk_rd(IDX_SEL, 8'ha1);
    chk_rd(IDX_P1_TOP, 8'hc3);
    $display("test data pointers done");
  endtask : t_pointer
  // program counter carries past bit 15 only in twenty bit mode; then a reset in mid-run
  task automatic t_wide;
    wr(IDX_MODE, 8'h02);
    cdrv.pc_value <= 20'h1ffff;
    cdrv.pc_load <= 1'b1;
    @(posedge mclk);
    cdrv.pc_load <= 1'b0;
    fetch_run(4'h1, 1'b1, 20'h20000);
    wr(IDX_MODE, 8'h00);
    cdrv.pc_load <= 1'b1;
    @(posedge mclk);
    cdrv.pc_load <= 1'b0;
    fetch_run(4'h1, 1'b1, 20'h00000);
    wr(IDX_MODE, 8'h0a);
    // no bus transfer or fetch is under way here
    arst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    chk_rd(IDX_WAIT, 8'h07);
    chk_rd(IDX_MODE, 8'h00);
    chk_rd(IDX_SEL, 8'h00);
    `CHK("prog_wide", 1'b0, core_o.prog_wide)
    $display("test wide addressing and reset done");
  endtask : t_wide
  // reset, then each scenario in turn
  initial begin
    arst_n <= 1'b0; // a real falling edge, so state is cleared before the first sample
    repeat (8) @(posedge mclk);
    arst_n <= 1'b1;
    t_reset();
    t_mode();
    t_indirect();
    t_fetch();
    t_pointer();
    t_wide();
    test_done();
  end
endmodule : data_pointer_address_control_tb
`undef CHK
`default_nettype wire

// >>> test/dpac_flash_model.sv
// program flash model with a settable access time
`timescale 1ns/1ps
`default_nettype none
module dpac_flash_model
  import dpac_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic flash_rd,
  input wire logic [19:0] flash_addr,
  input wire logic [4:0] access_cyc,
  output logic [7:0] flash_data
);
  logic [4:0] held;
  logic [19:0] last_addr;
  logic junk;
  // count cycles one address has been read; a new address restarts the access
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      held <= 5'h00;
      last_addr <= 20'h00000;
      junk <= 1'b0;
    end else begin
      junk <= ~junk;
      last_addr <= flash_addr;
      if (!flash_rd || flash_addr != last_addr) begin
        held <= 5'h00;
      end else if (held != 5'h1f) begin
        held <= held + 5'h01;
      end
    end
  end
  // data only once the access time is over; a toggling pattern otherwise so early capture shows
  assign flash_data = (flash_rd && (held + 5'h01) >= access_cyc) ? (flash_addr[7:0] ^ 8'h5a)
                                                                   : {8{junk}};
endmodule : dpac_flash_model
`default_nettype wire
